// ===== hw/period_match_timer8.sv
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`include "period_match_timer8_cfg.svh"
// 8-bit period match timer with AHB-Lite register access
module period_match_timer8 (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // neighbours
    output logic             match_pulse,
    output logic      [7:0]  pwm_count,
    output logic      [7:0]  pwm_period,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        period_match_timer8_pkg::bus_phase_t ph;
        logic [11:0] addr;
        logic [7:0]  count;
        logic [6:0]  ctl;
        logic [7:0]  period;
        logic [3:0]  post;
        logic        flag;
        logic        en;
        logic        match;
        logic [31:0] rdata;
    } tmr_state_t;

    tmr_state_t s_q;
    tmr_state_t s_d;
    logic       tick;
    logic       wr_count;
    logic       wr_ctl;
    logic       presc_clear;
    logic       hit;
    logic       post_done;

    // register read mux, used for the data phase capture
    function automatic logic [31:0] read_reg(input logic [11:0] a, input tmr_state_t s);
        case (a)
            `PMT_OFS_COUNT:   read_reg = {24'h0, s.count};
            `PMT_OFS_CONTROL: read_reg = {25'h0, s.ctl};
            `PMT_OFS_PERIOD:  read_reg = {24'h0, s.period};
            `PMT_OFS_STATUS:  read_reg = {31'h0, s.flag};
            `PMT_OFS_ENABLE:  read_reg = {31'h0, s.en};
            default:          read_reg = 32'h0;
        endcase
    endfunction

    assign wr_count    = (s_q.ph == period_match_timer8_pkg::ph_write) && (s_q.addr == `PMT_OFS_COUNT);
    assign wr_ctl      = (s_q.ph == period_match_timer8_pkg::ph_write) && (s_q.addr == `PMT_OFS_CONTROL);
    assign presc_clear = wr_count || wr_ctl;
    assign hit         = tick && (s_q.count == s_q.period);
    assign post_done   = s_q.post == s_q.ctl[`PMT_CTL_POST_LSB +: 4];

    tick_divider u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (s_q.ctl[`PMT_CTL_RUN_BIT]),
        .clear   (presc_clear),
        .pre_sel (s_q.ctl[`PMT_CTL_PRE_LSB +: 2]),
        .tick    (tick)
    );

    // bus phases plus counter, postscaler and flag
    always_comb begin
        s_d       = s_q;
        s_d.match = hit;
        s_d.ph    = period_match_timer8_pkg::ph_idle;
        if (hsel && hready && htrans[1]) begin
            s_d.addr = haddr;
            s_d.ph   = hwrite ? period_match_timer8_pkg::ph_write : period_match_timer8_pkg::ph_read;
            if (!hwrite) begin
                s_d.rdata = read_reg(haddr, s_q);
            end
        end
        if (hit) begin
            s_d.count = 8'h00;
            s_d.post  = post_done ? 4'h0 : s_q.post + 4'h1;
        end else if (tick) begin
            s_d.count = s_q.count + 8'h01;
        end
        if (hit && post_done) begin
            s_d.flag = 1'b1;
        end
        if (presc_clear) begin
            s_d.post = 4'h0;
        end
        if (s_q.ph == period_match_timer8_pkg::ph_write) begin
            case (s_q.addr)
                `PMT_OFS_COUNT:   s_d.count  = hwdata[7:0];
                `PMT_OFS_CONTROL: s_d.ctl    = hwdata[6:0];
                `PMT_OFS_PERIOD:  s_d.period = hwdata[7:0];
                `PMT_OFS_ENABLE:  s_d.en     = hwdata[`PMT_STAT_MATCH];
                `PMT_OFS_CLEAR: begin
                    // a new event in the same cycle wins over the clear
                    if (hwdata[`PMT_STAT_MATCH] && !(hit && post_done)) begin
                        s_d.flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q        <= '0;
            s_q.count  <= `PMT_RST_COUNT;
            s_q.ctl    <= 7'h00;
            s_q.period <= `PMT_RST_PERIOD;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata      = s_q.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign match_pulse = s_q.match;
    assign pwm_count   = s_q.count;
    assign pwm_period  = s_q.period;
    assign irq         = s_q.flag && s_q.en;

    // checks
    a_count_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        hit && !wr_count |=> s_q.count == 8'h00) else $error("count did not wrap");
    a_period_rst: assert property (@(posedge hclk) $rose(hresetn) |-> s_q.period == 8'hff)
        else $error("period reset wrong");
    a_ctl_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctl && !tick |=> s_q.count == $past(s_q.count)) else $error("control write moved count");
    a_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_q.ctl[2] && !wr_count |=> $stable(s_q.count)) else $error("stopped timer counted");
    a_match_out: assert property (@(posedge hclk) disable iff (!hresetn)
        hit |=> match_pulse) else $error("match pulse missing");
    a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        hit && post_done |=> s_q.flag) else $error("flag not set");
    a_post_clr: assert property (@(posedge hclk) disable iff (!hresetn)
        presc_clear |=> s_q.post == 4'h0) else $error("postscaler not cleared");
    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        irq |-> s_q.flag && s_q.en) else $error("irq without flag");
    a_bit7_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.ph == period_match_timer8_pkg::ph_read && s_q.addr == `PMT_OFS_CONTROL |-> hrdata[7] == 1'b0)
        else $error("control bit 7 set");
    c_match: cover property (@(posedge hclk) disable iff (!hresetn) hit);
    c_flag: cover property (@(posedge hclk) disable iff (!hresetn) $rose(s_q.flag));
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

// ===== hw/period_match_timer8_cfg.svh
// Contract
// - counter ticks on instruction clock (hclk/4) through prescaler of 1, 4 or 16.
// - control bits 1:0 pick prescale: 00 by 1, 01 by 4, 1x by 16.
// - counter counts up from zero to period, then wraps to zero next increment.
// - period register is software read/write and resets to all ones.
// - counter register is software read/write and resets to zero.
// - each match feeds a 4-bit postscaler that sets the match flag at its count.
// - postscale field bits 6:3, value n sets flag every n+1 matches.
// - prescale and postscale counts clear on counter write, control write, reset.
// - writing the control register leaves the counter value unchanged.
// - control bit 2 enables counting; clear stops the timer.
// - match pulse before the postscaler goes out to the serial port.
// - counter and period are offered to the PWM unit as time base.
// - control bit 7 reads zero; all implemented control bits reset to zero.
`ifndef PERIOD_MATCH_TIMER8_CFG_SVH
`define PERIOD_MATCH_TIMER8_CFG_SVH
`define PMT_OFS_COUNT     12'h000
`define PMT_OFS_CONTROL   12'h004
`define PMT_OFS_PERIOD    12'h008
`define PMT_OFS_STATUS    12'h00c
`define PMT_OFS_ENABLE    12'h010
`define PMT_OFS_CLEAR     12'h014
`define PMT_CTL_PRE_LSB   0
`define PMT_CTL_RUN_BIT   2
`define PMT_CTL_POST_LSB  3
`define PMT_CTL_MASK      8'h7f
`define PMT_RST_COUNT     8'h00
`define PMT_RST_CONTROL   8'h00
`define PMT_RST_PERIOD    8'hff
`define PMT_INSTR_DIV     2'h3
`define PMT_PRE_4_TOP     4'h3
`define PMT_PRE_16_TOP    4'hf
`define PMT_STAT_MATCH    0
`endif

// ===== hw/period_match_timer8_pkg.sv
package period_match_timer8_pkg;
    typedef enum logic [1:0] {
        ph_idle  = 2'b00,
        ph_write = 2'b01,
        ph_read  = 2'b10
    } bus_phase_t;
endpackage

// ===== hw/tick_divider.sv
`include "period_match_timer8_cfg.svh"
// instruction clock and prescaler: one tick every 4, 16 or 64 hclk cycles
module tick_divider (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [1:0] pre_sel,
    // tick out
    output logic            tick
);
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] pre;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;
    logic       instr_tick;
    logic [3:0] pre_top;

    // prescale top count from the select code
    always_comb begin
        case (pre_sel)
            2'b00:   pre_top = 4'h0;
            2'b01:   pre_top = `PMT_PRE_4_TOP;
            default: pre_top = `PMT_PRE_16_TOP;
        endcase
    end

    assign instr_tick = run && (s_q.phase == `PMT_INSTR_DIV);
    assign tick       = instr_tick && (s_q.pre >= pre_top);

    // phase divider keeps running only while enabled, to save power
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d.phase = 2'h0;
            s_d.pre   = 4'h0;
        end else if (run) begin
            s_d.phase = s_q.phase + 2'h1;
            if (instr_tick) begin
                s_d.pre = tick ? 4'h0 : s_q.pre + 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, match_pulse, irq;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0]  pwm_count, pwm_period;
    int          failures, num_checks, n, k;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d;} row_t;
    // reads carry the expected value in d
    row_t rows[16] = '{'{1'h0, 12'h000, 32'h0}, '{1'h0, 12'h004, 32'h0}, '{1'h0, 12'h008, 32'hff},
        '{1'h1, 12'h008, 32'hffffff5a}, '{1'h0, 12'h008, 32'h5a},
        '{1'h1, 12'h004, 32'hfb}, '{1'h0, 12'h004, 32'h7b},
        '{1'h1, 12'h000, 32'h33}, '{1'h0, 12'h000, 32'h33},
        '{1'h1, 12'h010, 32'h1}, '{1'h0, 12'h010, 32'h1}, '{1'h1, 12'h014, 32'h1}, '{1'h0, 12'h014, 32'h0},
        '{1'h1, 12'h100, 32'hff}, '{1'h0, 12'h100, 32'h0}, '{1'h0, 12'h00c, 32'h0}};
    logic [3:0]  pv[3] = '{4'h0, 4'h2, 4'hf};

    period_match_timer8 uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .match_pulse(match_pulse), .pwm_count(pwm_count),
        .pwm_period(pwm_period), .irq(irq));

    // 100 ns clock
    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // one single transfer; waits on hready in both phases, no cycle count assumed
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    task automatic run_rows(input int hi);
        for (int i = 0; i < hi; i++) begin
            xfer(rows[i].w, rows[i].a, rows[i].d, rd);
            if (!rows[i].w) chk($sformatf("reg %h", rows[i].a), rows[i].d, rd);
        end
    endtask

    // cycles between two match pulses with period 1 (two ticks per match)
    task automatic gap(input logic [1:0] pre, input int exp);
        xfer(1'h1, 12'h008, 32'h1, rd);
        xfer(1'h1, 12'h000, 32'h0, rd);
        xfer(1'h1, 12'h004, {29'h0, 1'h1, pre}, rd);
        k = 0;
        while (match_pulse !== 1'h1 && k < 1000) begin
            @(posedge hclk);
            k++;
        end
        // the control write may catch a tick of the old setting, so skip one pulse
        @(posedge hclk);
        while (match_pulse !== 1'h1 && k < 2000) begin
            @(posedge hclk);
            k++;
        end
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (match_pulse !== 1'h1 && n < 1000);
        chk("match gap", exp, n);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog well beyond the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        test_done();
    end

    initial begin
        {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        hresetn = 1'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        run_rows(16);
        gap(2'h0, 8);
        gap(2'h1, 32);
        gap(2'h2, 128);
        gap(2'h3, 128);
        chk("pwm period", 32'h1, pwm_period);
        // postscaler: irq must follow exactly n+1 matches
        foreach (pv[i]) begin
            xfer(1'h1, 12'h004, 32'h0, rd);
            xfer(1'h1, 12'h000, 32'h0, rd);
            xfer(1'h1, 12'h014, 32'h1, rd);
            xfer(1'h1, 12'h004, {25'h0, pv[i], 3'h4}, rd);
            n = 0;
            k = 0;
            // irq rises with the last pulse, so count that pulse before leaving
            while (k < 2000) begin
                if (match_pulse === 1'h1) n++;
                if (irq === 1'h1) break;
                @(posedge hclk);
                k++;
            end
            chk("post count", pv[i] + 1, n);
        end
        xfer(1'h1, 12'h010, 32'h0, rd);
        xfer(1'h0, 12'h00c, 32'h0, rd);
        chk("sticky flag", 32'h1, rd);
        chk("masked irq", 32'h0, irq);
        xfer(1'h1, 12'h014, 32'h1, rd);
        xfer(1'h0, 12'h00c, 32'h0, rd);
        chk("cleared flag", 32'h0, rd);
        // stopped counter holds, control write leaves it alone
        xfer(1'h1, 12'h004, 32'h0, rd);
        xfer(1'h1, 12'h000, 32'h42, rd);
        repeat (100) @(posedge hclk);
        xfer(1'h1, 12'h004, 32'h78, rd);
        xfer(1'h0, 12'h000, 32'h0, rd);
        chk("held count", 32'h42, rd);
        chk("pwm count", 32'h42, pwm_count);
        chk("hresp", 32'h0, hresp);
        // reset in mid-run restores reset values
        xfer(1'h1, 12'h004, 32'h4, rd);
        repeat (20) @(posedge hclk);
        hresetn <= 1'h0;
        @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        run_rows(3);
        test_done();
    end
endmodule
